// ---- verilog/ccr_pkg.sv ----
// Package with register map, field positions, reset values and types of the correlation regs.
`default_nettype none
package ccr_pkg;

  // ----------------------------------------------------------------
  // Register offsets.
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_COMMAND = 8'h40;
  localparam logic [7:0] OFF_PREAMP_DC_LEVEL = 8'h42;
  localparam logic [7:0] OFF_TRANSMIT_DRIVE_LEVELS = 8'h43;
  localparam logic [7:0] OFF_MEASUREMENT_INTERVAL = 8'h45;
  localparam logic [7:0] OFF_HEALTH_FLAGS = 8'h48;
  localparam logic [7:0] OFF_SAMPLER_DC_VALUE = 8'h49;
  localparam logic [7:0] OFF_ECHO_MODE_CONFIG = 8'h4B;
  localparam logic [7:0] OFF_SECOND_PEAK_VALUE = 8'h4C;
  localparam logic [7:0] OFF_INNER_LOOP_COUNTER = 8'h4D;
  localparam logic [7:0] OFF_FIRMWARE_REVISION = 8'h4F;
  localparam logic [7:0] OFF_RECORD_WINDOW = 8'h51;
  localparam logic [7:0] OFF_MEMORY_READ_DATA = 8'h52;
  localparam logic [7:0] OFF_ACQUISITION_CONTROL = 8'h53;
  localparam logic [7:0] OFF_RECORD_NOISE_PEAK = 8'h5A;
  localparam logic [7:0] OFF_RESET_CONTROL = 8'h5C;
  localparam logic [7:0] OFF_MEMORY_SELECT = 8'h5D;
  localparam logic [7:0] OFF_MEASURED_TX_POWER = 8'h5F;
  localparam logic [7:0] OFF_FINE_DELAY = 8'h60;
  localparam logic [7:0] OFF_PEAK_INDEX_HIGH = 8'h61;
  localparam logic [7:0] OFF_PEAK_INDEX_LOW = 8'h62;
  localparam logic [7:0] OFF_CROSSING_UPPER_VALUE = 8'h63;
  localparam logic [7:0] OFF_CROSSING_LOWER_VALUE = 8'h64;
  localparam logic [7:0] OFF_POWER_CONTROL = 8'h65;

  // ----------------------------------------------------------------
  // Writable bit masks, field positions and reset values.
  // ----------------------------------------------------------------
  localparam logic [7:0] MASK_ECHO_MODE = 8'h97;
  localparam logic [7:0] MASK_MEMORY_SELECT = 8'hC0;
  localparam logic [3:0] MASK_POWER = 4'hF;
  localparam int MODE_SKIP_DC_BIT = 7;
  localparam int MODE_RECORD_SEL_BIT = 4;
  localparam int MODE_MAX_RANGE_BIT = 2;
  localparam int MODE_RANGE_CRIT_BIT = 1;
  localparam int MODE_SECOND_RET_BIT = 0;
  localparam int PWR_DET_BIAS_BIT = 3;
  localparam int PWR_SLEEP_BIT = 2;
  localparam int PWR_RCVR_BIT = 1;
  localparam int PWR_PREAMP_BIT = 0;
  localparam int SEGMENT_SHIFT = 6;
  localparam logic [7:0] RST_MEAS_INTERVAL = 8'hC8;
  localparam logic [7:0] DEFAULT_SPACING = 8'hC8;
  localparam logic [3:0] RST_POWER = 4'h0;
  localparam logic [4:0] FINE_DELAY_MAX = 5'h1D;
  localparam logic [4:0] FINE_DELAY_SPAN = 5'h1E;

  // ----------------------------------------------------------------
  // Timing: one interval unit is 500 us at a 5 ns clock.
  // ----------------------------------------------------------------
  localparam int INTERVAL_UNIT_NS = 500000;
  localparam int CLK_PERIOD_NS = 5;
  localparam int INTERVAL_UNIT_CYCLES = INTERVAL_UNIT_NS / CLK_PERIOD_NS;

  // Measured values handed in by the correlation core.
  typedef struct packed {
    logic [3:0] health;
    logic [7:0] samplerDc;
    logic [7:0] secondPeak;
    logic [7:0] rawNoise;
    logic rawNoiseValid;
    logic [7:0] txPower;
    logic [15:0] peakIndex;
    logic [7:0] crossUpper;
    logic [7:0] crossLower;
    logic crossValid;
    logic [8:0] memWord;
  } ccr_core_t;

  // One candidate echo.
  typedef struct packed {
    logic [15:0] range;
    logic [7:0] peak;
  } ccr_echo_t;

endpackage
`default_nettype wire

// ---- verilog/ccr_regs.sv ----
// Correlation core external register bank with echo selection, interval timer and power control.
//
// Overview of operation
// - Keep full-range preamp DC level for servo.
// - Upper nibble reference drive, lower signal drive.
// - Interval register sets measurement spacing.
// - Programmed interval only with velocity scale set.
// - Health flags in bits zero to three.
// - Read back sampler DC level.
// - Mode bit seven skips DC stabilization.
// - Mode bit four picks reference/signal record.
// - Mode bit two picks farther echo.
// - Mode bit one selects by distance.
// - Mode bit zero reports alternative echo.
// - Read back second largest peak value.
// - Window register gives start/stop segments.
// - Data register returns low byte; sign aside.
// - Memory select bits choose readable memory.
// - Noise peak stored scaled by 1.25.
// - Fine delay reported within 0 to 29.
// - Peak index read as high/low bytes.
// - Crossing values stored and interpolate fine delay.
// - Sleep bit; wake on bus transaction.
// - Read back measured transmit power.
// - Command write starts operation at once.
`timescale 1ns/100ps
`default_nettype none
module ccr_regs #(
  parameter int TICK_CYCLES = ccr_pkg::INTERVAL_UNIT_CYCLES,
  parameter logic [7:0] FW_REVISION = 8'h01  // Arbitrary value.
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] regAddr,
  input wire logic regWrEn,
  input wire logic [7:0] regWrData,
  input wire logic regRdEn,
  output logic [7:0] regRdData,
  output logic regRdValid,
  input wire logic busActivity,
  input wire logic velocityScale,
  input wire ccr_pkg::ccr_core_t core,
  input wire ccr_pkg::ccr_echo_t echoNear,
  input wire ccr_pkg::ccr_echo_t echoFar,
  output logic cmdStart,
  output logic [7:0] cmdValue,
  output logic recordSelect,
  output logic [7:0] preampDcLevel,
  output logic [3:0] refDrive,
  output logic [3:0] sigDrive,
  output logic measTick,
  output logic skipDcStab,
  output logic [15:0] selectedRange,
  output logic selectedFar,
  output logic [3:0] winStart,
  output logic [3:0] winStop,
  output logic [1:0] memSelect,
  output logic memSignBit,
  output logic [7:0] noisePeak,
  output logic [4:0] fineDelay,
  output logic [7:0] resetControl,
  output logic detBiasOff,
  output logic sleepActive,
  output logic receiver_supply_off,
  output logic oscillator_off,
  output logic preampOff
);

  // ----------------------------------------------------------------
  // State.
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] preampDc;
    logic [7:0] txDrive;
    logic [7:0] measInterval;
    logic [7:0] modeCfg;
    logic [7:0] innerLoop;
    logic [7:0] window;
    logic [7:0] acqCtrl;
    logic [7:0] resetCtrl;
    logic [7:0] memSel;
    logic [7:0] crossUp;
    logic [7:0] crossLow;
    logic [3:0] power;
    logic [7:0] noise;
    logic [4:0] fine;
    logic [7:0] rdData;
    logic rdValid;
    logic cmdStart;
    logic [7:0] cmdValue;
    logic measTick;
    logic [16:0] tickCnt;
    logic [7:0] unitCnt;
    logic [15:0] echoRange;
    logic echoFar;
    logic busSync1;
    logic busSync2;
    logic busPrev;
  } ccr_state_t;

  ccr_state_t state_q;
  ccr_state_t state_d;

  // Linear interpolation of the zero crossing across one coarse step.
  function automatic logic [4:0] ccr_interp(input logic [7:0] up, input logic [7:0] low);
    logic [12:0] num;
    logic [8:0] den;
    logic [12:0] quo;
    num = 13'(up) * 13'(ccr_pkg::FINE_DELAY_SPAN);
    den = 9'(up) + 9'(low);
    quo = (den == 9'h000) ? 13'h0000 : num / 13'(den);
    if (quo > 13'(ccr_pkg::FINE_DELAY_MAX)) begin
      quo = 13'(ccr_pkg::FINE_DELAY_MAX);
    end
    return quo[4:0];
  endfunction

  logic busWake;
  logic accessOk;
  logic [8:0] noiseScaled;
  logic [7:0] spacing;
  logic nearIsStronger;
  logic primaryFar;

  // ----------------------------------------------------------------
  // Next-state logic.
  // ----------------------------------------------------------------
  // Register accesses are ignored while asleep; a waking transaction is thrown away if its strobe comes within two cycles of the bus activity edge.
  always_comb begin
    state_d = state_q;
    busWake = state_q.busSync2 & ~state_q.busPrev;
    accessOk = ~state_q.power[ccr_pkg::PWR_SLEEP_BIT];
    noiseScaled = 9'(core.rawNoise) + 9'(core.rawNoise[7:2]);
    spacing = velocityScale ? state_q.measInterval : ccr_pkg::DEFAULT_SPACING;
    nearIsStronger = echoNear.peak >= echoFar.peak;
    state_d.busSync1 = busActivity;
    state_d.busSync2 = state_q.busSync1;
    state_d.busPrev = state_q.busSync2;
    state_d.cmdStart = 1'b0;
    state_d.rdValid = 1'b0;
    state_d.measTick = 1'b0;

    // Host writes; unused bits are masked off.
    if (regWrEn && accessOk) begin
      unique case (regAddr)
        ccr_pkg::OFF_COMMAND: begin
          state_d.cmdStart = 1'b1;
          state_d.cmdValue = regWrData;
        end
        ccr_pkg::OFF_PREAMP_DC_LEVEL: state_d.preampDc = regWrData;
        ccr_pkg::OFF_TRANSMIT_DRIVE_LEVELS: state_d.txDrive = regWrData;
        ccr_pkg::OFF_MEASUREMENT_INTERVAL: state_d.measInterval = regWrData;
        ccr_pkg::OFF_ECHO_MODE_CONFIG: state_d.modeCfg = regWrData & ccr_pkg::MASK_ECHO_MODE;
        ccr_pkg::OFF_INNER_LOOP_COUNTER: state_d.innerLoop = regWrData;
        ccr_pkg::OFF_RECORD_WINDOW: state_d.window = regWrData;
        ccr_pkg::OFF_ACQUISITION_CONTROL: state_d.acqCtrl = regWrData;
        ccr_pkg::OFF_RESET_CONTROL: state_d.resetCtrl = regWrData;
        ccr_pkg::OFF_MEMORY_SELECT: state_d.memSel = regWrData & ccr_pkg::MASK_MEMORY_SELECT;
        ccr_pkg::OFF_CROSSING_UPPER_VALUE: state_d.crossUp = regWrData;
        ccr_pkg::OFF_CROSSING_LOWER_VALUE: state_d.crossLow = regWrData;
        ccr_pkg::OFF_POWER_CONTROL: state_d.power = regWrData[3:0] & ccr_pkg::MASK_POWER;
        default: ;
      endcase
    end

    // Host reads; write-only and unmapped offsets return zero.
    if (regRdEn && accessOk) begin
      state_d.rdValid = 1'b1;
      state_d.rdData = 8'h00;
      unique case (regAddr)
        ccr_pkg::OFF_PREAMP_DC_LEVEL: state_d.rdData = state_q.preampDc;
        ccr_pkg::OFF_TRANSMIT_DRIVE_LEVELS: state_d.rdData = state_q.txDrive;
        ccr_pkg::OFF_MEASUREMENT_INTERVAL: state_d.rdData = state_q.measInterval;
        ccr_pkg::OFF_HEALTH_FLAGS: state_d.rdData = {4'h0, core.health};
        ccr_pkg::OFF_SAMPLER_DC_VALUE: state_d.rdData = core.samplerDc;
        ccr_pkg::OFF_ECHO_MODE_CONFIG: state_d.rdData = state_q.modeCfg;
        ccr_pkg::OFF_SECOND_PEAK_VALUE: state_d.rdData = core.secondPeak;
        ccr_pkg::OFF_INNER_LOOP_COUNTER: state_d.rdData = state_q.innerLoop;
        ccr_pkg::OFF_FIRMWARE_REVISION: state_d.rdData = FW_REVISION;
        ccr_pkg::OFF_MEMORY_READ_DATA: begin
          if (state_q.memSel[7:6] != 2'b00) begin
            state_d.rdData = core.memWord[7:0];
            state_d.acqCtrl[0] = core.memWord[8];
          end
        end
        ccr_pkg::OFF_RECORD_NOISE_PEAK: state_d.rdData = state_q.noise;
        ccr_pkg::OFF_RESET_CONTROL: state_d.rdData = state_q.resetCtrl;
        ccr_pkg::OFF_MEMORY_SELECT: state_d.rdData = state_q.memSel;
        ccr_pkg::OFF_MEASURED_TX_POWER: state_d.rdData = core.txPower;
        ccr_pkg::OFF_FINE_DELAY: state_d.rdData = {3'h0, state_q.fine};
        ccr_pkg::OFF_PEAK_INDEX_HIGH: state_d.rdData = core.peakIndex[15:8];
        ccr_pkg::OFF_PEAK_INDEX_LOW: state_d.rdData = core.peakIndex[7:0];
        ccr_pkg::OFF_CROSSING_UPPER_VALUE: state_d.rdData = state_q.crossUp;
        ccr_pkg::OFF_CROSSING_LOWER_VALUE: state_d.rdData = state_q.crossLow;
        default: ;
      endcase
    end

    // Core captures win over a host write in the same cycle, so no crossing is lost.
    if (core.crossValid) begin
      state_d.crossUp = core.crossUpper;
      state_d.crossLow = core.crossLower;
    end
    state_d.fine = ccr_interp(state_q.crossUp, state_q.crossLow);

    // Noise scaled by 1.25 and saturated at a full byte.
    if (core.rawNoiseValid) begin
      state_d.noise = noiseScaled[8] ? 8'hFF : noiseScaled[7:0];
    end

    // Echo choice: strongest or by distance, then optionally the other one.
    primaryFar = state_q.modeCfg[ccr_pkg::MODE_RANGE_CRIT_BIT] ?
        state_q.modeCfg[ccr_pkg::MODE_MAX_RANGE_BIT] : ~nearIsStronger;
    state_d.echoFar = primaryFar ^ state_q.modeCfg[ccr_pkg::MODE_SECOND_RET_BIT];
    state_d.echoRange = state_d.echoFar ? echoFar.range : echoNear.range;

    // Interval timer stops in sleep; a zero interval behaves like one unit.
    if (state_q.power[ccr_pkg::PWR_SLEEP_BIT]) begin
      state_d.tickCnt = 17'h00000;
      state_d.unitCnt = 8'h00;
    end else if (state_q.tickCnt >= 17'(TICK_CYCLES - 1)) begin
      state_d.tickCnt = 17'h00000;
      if (state_q.unitCnt + 8'h01 >= spacing) begin
        state_d.unitCnt = 8'h00;
        state_d.measTick = 1'b1;
      end else begin
        state_d.unitCnt = state_q.unitCnt + 8'h01;
      end
    end else begin
      state_d.tickCnt = state_q.tickCnt + 17'h00001;
    end

    // A bus transaction wakes the block; the wake wins over a same-cycle sleep write.
    if (busWake) begin
      state_d.power[ccr_pkg::PWR_SLEEP_BIT] = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // State register.
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_q <= '0;
      state_q.measInterval <= ccr_pkg::RST_MEAS_INTERVAL;
      state_q.power <= ccr_pkg::RST_POWER;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all taken from the state register.
  // ----------------------------------------------------------------
  assign regRdData = state_q.rdData;
  assign regRdValid = state_q.rdValid;
  assign cmdStart = state_q.cmdStart;
  assign cmdValue = state_q.cmdValue;
  assign recordSelect = state_q.modeCfg[ccr_pkg::MODE_RECORD_SEL_BIT];
  assign preampDcLevel = state_q.preampDc;
  assign refDrive = state_q.txDrive[7:4];
  assign sigDrive = state_q.txDrive[3:0];
  assign measTick = state_q.measTick;
  assign skipDcStab = state_q.modeCfg[ccr_pkg::MODE_SKIP_DC_BIT];
  assign selectedRange = state_q.echoRange;
  assign selectedFar = state_q.echoFar;
  assign winStart = state_q.window[3:0];
  assign winStop = state_q.window[7:4];
  assign memSelect = state_q.memSel[7:6];
  assign memSignBit = state_q.acqCtrl[0];
  assign noisePeak = state_q.noise;
  assign fineDelay = state_q.fine;
  assign resetControl = state_q.resetCtrl;
  assign detBiasOff = state_q.power[ccr_pkg::PWR_DET_BIAS_BIT];
  assign sleepActive = state_q.power[ccr_pkg::PWR_SLEEP_BIT];
  assign receiver_supply_off = state_q.power[ccr_pkg::PWR_RCVR_BIT];
  assign oscillator_off = state_q.power[ccr_pkg::PWR_RCVR_BIT];
  assign preampOff = state_q.power[ccr_pkg::PWR_PREAMP_BIT];

  // ----------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  AST_CMD_PULSE: assert property ((regWrEn && regAddr == ccr_pkg::OFF_COMMAND && !sleepActive)
      |=> cmdStart && cmdValue == $past(regWrData) ##1 !cmdStart)
    else $error("Command write did not give a one-cycle start.");
  AST_MODE_MASK: assert property ((regWrEn && regAddr == ccr_pkg::OFF_ECHO_MODE_CONFIG
      && !sleepActive) |=> state_q.modeCfg == ($past(regWrData) & 8'h97))
    else $error("Mode register kept unused bits.");
  AST_FINE_RANGE: assert property (fineDelay <= 5'd29)
    else $error("Fine delay above 29.");
  AST_SLEEP_IGNORES: assert property ((sleepActive && regRdEn && !$past(busActivity))
      |=> !regRdValid)
    else $error("Access taken while asleep.");
  AST_HEALTH_READ: assert property ((regRdEn && regAddr == ccr_pkg::OFF_HEALTH_FLAGS
      && !sleepActive) |=> regRdValid && regRdData == {4'h0, $past(core.health)})
    else $error("Health flags read wrong.");
  AST_NOISE_SCALE: assert property ((core.rawNoiseValid && core.rawNoise == 8'h20)
      |=> noisePeak == 8'h28)
    else $error("Noise peak not scaled by 1.25.");
  AST_ECHO_FAR: assert property ((state_q.modeCfg[2:0] == 3'b110) |=> selectedFar)
    else $error("Farther echo not chosen.");
  AST_ECHO_ALT: assert property ((state_q.modeCfg[2:0] == 3'b011) |=> selectedFar)
    else $error("Alternative echo not reported.");
  AST_DEFAULT_SPACING: assert property ((!velocityScale && measTick && !sleepActive)
      |-> state_q.unitCnt == 8'h00)
    else $error("Interval tick out of step.");
  AST_MEM_LOW_BYTE: assert property ((regRdEn && regAddr == ccr_pkg::OFF_MEMORY_READ_DATA
      && !sleepActive && memSelect != 2'b00) |=> regRdData == $past(core.memWord[7:0])
      && memSignBit == $past(core.memWord[8]))
    else $error("Memory data read wrong.");

  COV_COMMAND: cover property (cmdStart);
  COV_SLEEP_WAKE: cover property (sleepActive ##[1:20] !sleepActive);
  COV_TICK: cover property (measTick);
  COV_MEM_READ: cover property (regRdValid && memSelect == 2'b11);

endmodule // ccr_regs
`default_nettype wire

// ---- tb/ccr_host_model.sv ----
// Host-side model that drives the byte strobe port of the correlation register bank.
`timescale 1ns/100ps
`default_nettype none
module ccr_host_model (
  input wire logic mclk,
  output var logic [7:0] regAddr,
  output var logic regWrEn,
  output var logic [7:0] regWrData,
  output var logic regRdEn,
  input wire logic [7:0] regRdData,
  input wire logic regRdValid,
  output var logic busActivity
);
  // Idle bus at time zero.
  initial begin
    regAddr = 8'h00;
    regWrEn = 1'b0;
    regWrData = 8'h00;
    regRdEn = 1'b0;
    busActivity = 1'b0;
  end

  // One byte access; bus activity leads the strobe by lead cycles, as an I2C start would.
  // A lead of zero models a throwaway transaction that arrives while the device sleeps.
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d,
                        input int lead, output logic [7:0] q, output logic got);
    logic [7:0] wd;
    wd = (wr && a == ccr_pkg::OFF_MEASUREMENT_INTERVAL && d < 8'h02) ? 8'h02 : d;
    @(posedge mclk);
    busActivity <= 1'b1;
    repeat (lead) @(posedge mclk);
    regAddr <= a;
    regWrData <= wd;
    regWrEn <= wr;
    regRdEn <= !wr;
    @(posedge mclk);
    regWrEn <= 1'b0;
    regRdEn <= 1'b0;
    busActivity <= 1'b0;
    // Released lines are scrambled so that nothing relies on a stale value.
    regAddr <= ~a;
    regWrData <= ~wd;
    #1;
    got = regRdValid;
    q = regRdData;
  endtask
endmodule  // ccr_host_model
`default_nettype wire

// ---- tb/ccr_regs_bench.sv ----
// Self-checking testbench of the correlation core register bank.
`timescale 1ns/100ps
`default_nettype none
module ccr_regs_bench;
  localparam int TICK = 4;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] regAddr, regWrData, regRdData, cmdValue, preampDcLevel, noisePeak, resetControl;
  logic regWrEn, regRdEn, regRdValid, busActivity, velocityScale, cmdStart, recordSelect;
  logic measTick, skipDcStab, selectedFar, memSignBit, detBiasOff, sleepActive;
  logic receiver_supply_off, oscillator_off, preampOff;
  logic [3:0] refDrive, sigDrive, winStart, winStop;
  logic [15:0] selectedRange;
  logic [1:0] memSelect;
  logic [4:0] fineDelay;
  ccr_pkg::ccr_core_t core;
  ccr_pkg::ccr_echo_t echoNear, echoFar;
  int n_errors = 0;
  int tests_run = 0;
  logic [31:0] seed = 32'h00000059;
  logic [31:0] v, w;
  logic [7:0] u, l, lastPre;
  logic [9:0] e;
  int n;

  // 200 MHz clock.
  always #2.5 mclk = ~mclk;

  ccr_regs #(.TICK_CYCLES(TICK)) uut (.mclk(mclk), .rst_n(rst_n), .regAddr(regAddr),
    .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
    .regRdValid(regRdValid), .busActivity(busActivity), .velocityScale(velocityScale),
    .core(core), .echoNear(echoNear), .echoFar(echoFar), .cmdStart(cmdStart),
    .cmdValue(cmdValue), .recordSelect(recordSelect), .preampDcLevel(preampDcLevel),
    .refDrive(refDrive), .sigDrive(sigDrive), .measTick(measTick), .skipDcStab(skipDcStab),
    .selectedRange(selectedRange), .selectedFar(selectedFar), .winStart(winStart),
    .winStop(winStop), .memSelect(memSelect), .memSignBit(memSignBit), .noisePeak(noisePeak),
    .fineDelay(fineDelay), .resetControl(resetControl), .detBiasOff(detBiasOff),
    .sleepActive(sleepActive), .receiver_supply_off(receiver_supply_off),
    .oscillator_off(oscillator_off), .preampOff(preampOff));

  ccr_host_model host (.mclk(mclk), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
    .regRdValid(regRdValid), .busActivity(busActivity));

  // ----------------------------------------------------------------
  // Helpers.
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Echo choice: distance rule or strongest (near wins a tie), then optional swap.
  function automatic logic exp_far(input logic [2:0] m, input logic [7:0] pn, input logic [7:0] pf);
    return (m[1] ? m[2] : (pf > pn)) ^ m[0];
  endfunction

  function automatic logic [4:0] exp_fine(input logic [7:0] up, input logic [7:0] lo);
    int q;
    q = (up + lo == 0) ? 0 : (30 * up) / (up + lo);
    return (q > 29) ? 5'h1D : q[4:0];
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t %s: seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input int lead = 3);
    logic [7:0] q;
    logic g;
    host.access(1'b1, a, d, lead, q, g);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input string msg);
    logic [7:0] q;
    logic g;
    host.access(1'b0, a, 8'h00, 3, q, g);
    chk({7'h00, g}, 16'h0001, "read answered");
    chk(q, exp, msg);
  endtask

  // Cycles from the present to the next interval tick, bounded.
  task automatic gap(output int c);
    c = 0;
    do begin
      @(posedge mclk);
      #1;
      c++;
    end while (measTick !== 1'b1 && c < 2000);
  endtask

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Watchdog sized well above the longest expected run.
  initial begin
    #250000;
    n_errors++;
    stop_test();
  end

  // ----------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------
  initial begin
    core = '0;
    echoNear = '0;
    echoFar = '0;
    velocityScale = 1'b0;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    #1;
    chk({detBiasOff, sleepActive, receiver_supply_off, oscillator_off, preampOff}, 0, "pwr");
    rdc(ccr_pkg::OFF_POWER_CONTROL, 8'h00, "power write-only");
    rdc(8'h7F, 8'h00, "unmapped read");
    $display("reset test done");
    for (int i = 0; i < 4; i++) begin
      v = rnd();
      lastPre = (i == 0) ? 8'hFF : v[7:0];
      wr(ccr_pkg::OFF_PREAMP_DC_LEVEL, lastPre);
      chk(preampDcLevel, lastPre, "preamp level");
      rdc(ccr_pkg::OFF_PREAMP_DC_LEVEL, lastPre, "preamp readback");
      wr(ccr_pkg::OFF_TRANSMIT_DRIVE_LEVELS, v[15:8]);
      chk({refDrive, sigDrive}, v[15:8], "drive nibbles");
      wr(ccr_pkg::OFF_ECHO_MODE_CONFIG, v[23:16]);
      rdc(ccr_pkg::OFF_ECHO_MODE_CONFIG, v[23:16] & 8'h97, "mode mask");
      chk({skipDcStab, recordSelect}, {v[23], v[20]}, "mode bits");
      wr(ccr_pkg::OFF_RECORD_WINDOW, v[31:24]);
      chk({winStop, winStart}, v[31:24], "window");
      rdc(ccr_pkg::OFF_RECORD_WINDOW, 8'h00, "window write-only");
      wr(ccr_pkg::OFF_RESET_CONTROL, v[7:0]);
      chk(resetControl, v[7:0], "reset control");
    end
    $display("settings test done");
    v = rnd();
    w = rnd();
    core.health <= v[3:0];
    core.samplerDc <= v[15:8];
    core.secondPeak <= v[23:16];
    core.txPower <= v[31:24];
    core.peakIndex <= w[15:0];
    rdc(ccr_pkg::OFF_HEALTH_FLAGS, {4'h0, v[3:0]}, "health");
    rdc(ccr_pkg::OFF_SAMPLER_DC_VALUE, v[15:8], "sampler dc");
    rdc(ccr_pkg::OFF_SECOND_PEAK_VALUE, v[23:16], "second peak");
    rdc(ccr_pkg::OFF_MEASURED_TX_POWER, v[31:24], "tx power");
    rdc(ccr_pkg::OFF_PEAK_INDEX_HIGH, w[15:8], "index high");
    rdc(ccr_pkg::OFF_PEAK_INDEX_LOW, w[7:0], "index low");
    $display("status test done");
    // Every selection mode, with equal peaks in the strongest-echo modes 4 and 5.
    for (int m = 0; m < 8; m++) begin
      v = rnd();
      w = rnd();
      if (m == 4 || m == 5) w[23:16] = v[23:16];
      echoNear <= {v[15:0], v[23:16]};
      echoFar <= {w[15:0], w[23:16]};
      wr(ccr_pkg::OFF_ECHO_MODE_CONFIG, {5'h00, m[2:0]});
      @(posedge mclk);
      #1;
      chk(selectedFar, exp_far(m[2:0], v[23:16], w[23:16]), "echo");
      chk(selectedRange, exp_far(m[2:0], v[23:16], w[23:16]) ? w[15:0] : v[15:0], "range");
    end
    $display("echo test done");
    w = rnd();
    core.memWord <= w[8:0];
    wr(ccr_pkg::OFF_ACQUISITION_CONTROL, 8'h01);
    chk(memSignBit, 1'b1, "sign from write");
    rdc(ccr_pkg::OFF_ACQUISITION_CONTROL, 8'h00, "acq write-only");
    for (int s = 3; s >= 0; s--) begin
      wr(ccr_pkg::OFF_MEMORY_SELECT, {s[1:0], 6'h3F});
      chk(memSelect, s[1:0], "memory select");
      rdc(ccr_pkg::OFF_MEMORY_SELECT, {s[1:0], 6'h00}, "select mask");
      rdc(ccr_pkg::OFF_MEMORY_READ_DATA, (s != 0) ? w[7:0] : 8'h00, "memory data");
      if (s != 0) chk(memSignBit, w[8], "memory sign");
    end
    $display("memory test done");
    for (int k = 0; k < 3; k++) begin
      v = rnd();
      u = (k == 0) ? 8'hFF : v[7:0];
      e = {2'b00, u} + {4'h0, u[7:2]};
      core.rawNoise <= u;
      core.rawNoiseValid <= 1'b1;
      @(posedge mclk);
      core.rawNoiseValid <= 1'b0;
      @(posedge mclk);
      #1;
      chk(noisePeak, (e > 10'd255) ? 8'hFF : e[7:0], "noise peak");
      u = (k == 0) ? 8'h00 : v[15:8];
      l = (k == 0) ? 8'h00 : ((k == 1) ? 8'h00 : v[23:16]);
      core.crossUpper <= u;
      core.crossLower <= l;
      core.crossValid <= 1'b1;
      @(posedge mclk);
      core.crossValid <= 1'b0;
      repeat (2) @(posedge mclk);
      #1;
      chk(fineDelay, exp_fine(u, l), "fine delay");
      rdc(ccr_pkg::OFF_FINE_DELAY, {3'h0, exp_fine(u, l)}, "fine readback");
      rdc(ccr_pkg::OFF_CROSSING_UPPER_VALUE, u, "upper value");
      rdc(ccr_pkg::OFF_CROSSING_LOWER_VALUE, l, "lower value");
    end
    $display("core strobe test done");
    // Spacing tables: programmed value only counts with velocity scale set.
    for (int t = 0; t < 3; t++) begin
      velocityScale <= (t != 2);
      wr(ccr_pkg::OFF_MEASUREMENT_INTERVAL, (t == 0) ? 8'h03 : 8'h13);
      gap(n);
      gap(n);
      chk(n, ((t == 0) ? 3 : ((t == 1) ? 19 : 200)) * TICK, "tick spacing");
    end
    $display("interval test done");
    // Command goes after the configuration tests, ahead of the power tests.
    v = rnd();
    wr(ccr_pkg::OFF_COMMAND, v[7:0]);
    chk({cmdStart, cmdValue}, {1'b1, v[7:0]}, "command start");
    @(posedge mclk);
    #1;
    chk(cmdStart, 1'b0, "command pulse ends");
    wr(ccr_pkg::OFF_POWER_CONTROL, 8'hFB);
    chk({detBiasOff, sleepActive, receiver_supply_off, oscillator_off, preampOff}, 5'h17, "pwr");
    wr(ccr_pkg::OFF_POWER_CONTROL, 8'h04);
    chk({detBiasOff, sleepActive, receiver_supply_off, oscillator_off, preampOff}, 5'h08, "slp");
    wr(ccr_pkg::OFF_PREAMP_DC_LEVEL, ~lastPre, 0);
    chk(preampDcLevel, lastPre, "write dropped in sleep");
    repeat (3) @(posedge mclk);
    #1;
    chk(sleepActive, 1'b0, "woken");
    rdc(ccr_pkg::OFF_PREAMP_DC_LEVEL, lastPre, "after wake");
    $display("power test done");
    stop_test();
  end
endmodule  // ccr_regs_bench
`default_nettype wire
